/* wavetable_voice_engine_consts.vh */
/*
 * Register offsets, field positions and timing counts for the
 * wavetable voice engine. Assumes byte addresses on AXI4-Lite.
 */
`ifndef WAVETABLE_VOICE_ENGINE_CONSTS_VH
`define WAVETABLE_VOICE_ENGINE_CONSTS_VH

`define CONVERTER_WORD_HIGH_IDX 8'h1D
`define CONVERTER_WORD_LOW_IDX 8'h1E
`define CONVERTER_CONTROL_IDX 8'h1F
`define VOICE_SELECT_TRIGGER_IDX 8'h20
`define PITCH_STEP_HIGH_IDX 8'h21
`define PITCH_STEP_LOW_IDX 8'h22
`define WAVE_ORIGIN_HIGH_IDX 8'h23
`define WAVE_ORIGIN_LOW_IDX 8'h24
`define SAMPLE_WIDTH_LOOP_HIGH_IDX 8'h25
`define LOOP_OFFSET_LOW_IDX 8'h26
`define ENVELOPE_ATTENUATION_HIGH_IDX 8'h27
`define ATTENUATION_LOW_IDX 8'h2A
`define SYNTH_RANGE_LAST_IDX 8'h2F

`define CONVERTER_ON_BIT 1
`define OUTPUT_SOURCE_SELECT_BIT 0
`define VOLUME_ONLY_UPDATE_BIT 7
`define PITCH_ONLY_UPDATE_BIT 6
`define SAMPLE_WIDTH_SELECT_BIT 7
`define RAMP_DIRECTION_BIT 7

`define CONVERTER_CONTROL_RESET 2'h0
`define END_MARKER 8'h80
`define UNITY_SHIFT_BASE 5'h11

`define CLOCK_HZ 100000000
`define OUTPUT_RATE_HZ 25000
`define TICK_CYCLES (`CLOCK_HZ / `OUTPUT_RATE_HZ)
`define ENVELOPE_TICK_DEFAULT 64

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* wavetable_voice_engine.v */
/*
 * Eight-voice wavetable playback engine with AXI4-Lite register slave.
 * Assumes a wave memory on the same clock answering one cycle after
 * the address (sample_memory_address -> sample_memory_data).
 */
// Added by the designer: the AXI4-Lite interface to the registers.
// What this block does
// - 16-bit converter word held in high byte and low byte registers.
// - converter control bit 1 switches converter on; off after reset.
// - converter control bit 0 picks mixed wavetable or software word.
// - no-function bits and unused synth addresses ignore writes, read zero.
// - voice register bits 2..0 select one of eight voices.
// - writing voice register with bits 7 and 6 zero starts that voice; software sets others first.
// - bit 7 volume-only, bit 6 pitch-only, both zero loads everything.
// - pointer advances by mantissa over two to seventeen minus shift.
// - wave start forms address bits 15..5, low five bits zero.
// - loop-high bit 7 selects 8-bit (0) or 12-bit (1) samples.
// - fetched value 80H is the end marker, not audio.
// - loop point is marker address plus loop field, carry dropped.
// - after first pass the loop span repeats; active voices are never stopped.
// - per-voice 10-bit attenuation, 000H loudest, 3FFH quietest.
// - attenuation stored separately per voice.
// - release steps selected low bits toward ones by span code.
// - attack steps them toward zeros; span 11 leaves it unchanged.
// - alternating direction writes give tremolo through the envelope.
// - 8-bit samples are signed raw PCM.
`include "wavetable_voice_engine_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module wavetable_voice_engine #(
	parameter ENVELOPE_TICKS = `ENVELOPE_TICK_DEFAULT // output ticks per ramp step
) (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, low active
	input wire [31:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write strobes
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [31:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	output reg [15:0] sample_memory_address, // wave memory word address
	input wire [15:0] sample_memory_data, // wave memory data, next cycle
	output reg [15:0] converter_input_word, // word to the converter
	output reg converter_on, // converter enable
	output reg output_tick // one-cycle pulse per output sample
);

	localparam ST_IDLE = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_MIX = 2'h3;

	// per-voice parameters
	reg [11:0] mant_reg [0:7];
	reg [3:0] shift_reg [0:7];
	reg [11:0] origin_reg [0:7];
	reg wide_reg [0:7];
	reg [9:0] loop_reg [0:7];
	reg dir_reg [0:7];
	reg [1:0] span_reg [0:7];
	reg [9:0] atten_reg [0:7];
	// per-voice playback state
	reg [27:0] pos_reg [0:7]; // 16 address bits . 12 fraction bits
	reg active_reg [0:7];
	reg signed [15:0] samp_reg [0:7];

	// staging registers written by software
	reg [7:0] conv_hi_reg, conv_lo_reg;
	reg [1:0] conv_ctl_reg;
	reg [7:0] voice_reg;
	reg [7:0] r21_reg, r22_reg, r23_reg, r24_reg, r25_reg, r26_reg;
	reg [7:0] r27_reg, r2a_reg;

	reg [1:0] state_reg;
	reg [2:0] vidx_reg;
	reg [15:0] tick_cnt_reg;
	reg [15:0] env_cnt_reg;
	reg env_step_reg;
	reg signed [19:0] acc_reg;

	reg aw_held_reg, w_held_reg;
	reg [7:0] aw_idx_reg;
	reg [7:0] w_byte_reg;
	reg w_en_reg;
	integer i;

	// step size: mantissa scaled by shift, 12 fraction bits
	function [27:0] pitch_inc;
		input [11:0] m;
		input [3:0] s;
		reg [5:0] sh;
		begin
			sh = 6'd17 - {2'b00, s};
			pitch_inc = ({16'h0000, m} << 12) >> sh;
		end
	endfunction

	// attenuation curve: 16 levels of 6 dB steps approximated by shifts
	function signed [15:0] scale;
		input signed [15:0] s;
		input [9:0] a;
		reg signed [15:0] t;
		begin
			t = s >>> a[9:6];
			scale = t - (((t >>> 6) * $signed({1'b0, a[5:0]})) >>> 1);
		end
	endfunction

	// envelope one-step move on the selected low bits
	function [9:0] ramp;
		input [9:0] a;
		input d;
		input [1:0] sp;
		reg [2:0] m;
		reg [2:0] f;
		begin
			m = (sp == 2'b00) ? 3'b111 : (sp == 2'b01) ? 3'b011 :
				(sp == 2'b10) ? 3'b001 : 3'b000;
			f = a[2:0] & m;
			ramp = a;
			if (m != 3'b000) begin
				if (!d && f != m)
					ramp = {a[9:3], (a[2:0] & ~m) | ((f + 3'd1) & m)};
				else if (d && f != 3'b000)
					ramp = {a[9:3], (a[2:0] & ~m) | ((f - 3'd1) & m)};
			end
		end
	endfunction

	function [7:0] byte_idx;
		input [31:0] a;
		begin
			byte_idx = a[9:2];
		end
	endfunction

	// write channel: take address and data in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_held_reg || aw_fire;
	wire w_have = w_held_reg || w_fire;
	wire [7:0] wr_idx = aw_held_reg ? aw_idx_reg : byte_idx(s_axi_awaddr);
	wire [7:0] wr_data = w_held_reg ? w_byte_reg : s_axi_wdata[7:0];
	wire wr_en = w_held_reg ? w_en_reg : s_axi_wstrb[0];
	wire wr_go = aw_have && w_have;
	wire wr_mapped = (wr_idx >= `CONVERTER_WORD_HIGH_IDX) &&
		(wr_idx <= `SYNTH_RANGE_LAST_IDX);
	wire wr_do = wr_go && wr_en;
	wire trig = wr_do && wr_idx == `VOICE_SELECT_TRIGGER_IDX;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_idx_reg <= 8'h00;
			w_byte_reg <= 8'h00;
			w_en_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_RESP_OKAY;
		end else begin
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			end else begin
				if (aw_fire) begin
					aw_held_reg <= 1'b1;
					aw_idx_reg <= byte_idx(s_axi_awaddr);
				end
				if (w_fire) begin
					w_held_reg <= 1'b1;
					w_byte_reg <= s_axi_wdata[7:0];
					w_en_reg <= s_axi_wstrb[0];
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software-written registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			conv_ctl_reg <= `CONVERTER_CONTROL_RESET;
			voice_reg <= 8'h00;
		end else if (wr_do) begin
			if (wr_idx == `CONVERTER_WORD_HIGH_IDX)
				conv_hi_reg <= wr_data;
			else if (wr_idx == `CONVERTER_WORD_LOW_IDX)
				conv_lo_reg <= wr_data;
			else if (wr_idx == `CONVERTER_CONTROL_IDX)
				conv_ctl_reg <= wr_data[1:0];
			else if (wr_idx == `VOICE_SELECT_TRIGGER_IDX)
				voice_reg <= {wr_data[7:6], 3'b000, wr_data[2:0]};
			else if (wr_idx == `PITCH_STEP_HIGH_IDX)
				r21_reg <= wr_data;
			else if (wr_idx == `PITCH_STEP_LOW_IDX)
				r22_reg <= wr_data;
			else if (wr_idx == `WAVE_ORIGIN_HIGH_IDX)
				r23_reg <= {4'h0, wr_data[3:0]};
			else if (wr_idx == `WAVE_ORIGIN_LOW_IDX)
				r24_reg <= wr_data;
			else if (wr_idx == `SAMPLE_WIDTH_LOOP_HIGH_IDX)
				r25_reg <= {wr_data[7], 5'h00, wr_data[1:0]};
			else if (wr_idx == `LOOP_OFFSET_LOW_IDX)
				r26_reg <= wr_data;
			else if (wr_idx == `ENVELOPE_ATTENUATION_HIGH_IDX)
				r27_reg <= {wr_data[7], 3'h0, wr_data[3:0]};
			else if (wr_idx == `ATTENUATION_LOW_IDX)
				r2a_reg <= wr_data;
		end
	end

	// read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `AXI_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			if (byte_idx(s_axi_araddr) == `CONVERTER_WORD_HIGH_IDX)
				s_axi_rdata[7:0] <= conv_hi_reg;
			else if (byte_idx(s_axi_araddr) == `CONVERTER_WORD_LOW_IDX)
				s_axi_rdata[7:0] <= conv_lo_reg;
			else if (byte_idx(s_axi_araddr) == `CONVERTER_CONTROL_IDX)
				s_axi_rdata[1:0] <= conv_ctl_reg;
			else if (byte_idx(s_axi_araddr) == `VOICE_SELECT_TRIGGER_IDX)
				s_axi_rdata[7:0] <= voice_reg;
			else if (byte_idx(s_axi_araddr) == `PITCH_STEP_HIGH_IDX)
				s_axi_rdata[7:0] <= r21_reg;
			else if (byte_idx(s_axi_araddr) == `PITCH_STEP_LOW_IDX)
				s_axi_rdata[7:0] <= r22_reg;
			else if (byte_idx(s_axi_araddr) == `WAVE_ORIGIN_HIGH_IDX)
				s_axi_rdata[7:0] <= r23_reg;
			else if (byte_idx(s_axi_araddr) == `WAVE_ORIGIN_LOW_IDX)
				s_axi_rdata[7:0] <= r24_reg;
			else if (byte_idx(s_axi_araddr) == `SAMPLE_WIDTH_LOOP_HIGH_IDX)
				s_axi_rdata[7:0] <= r25_reg;
			else if (byte_idx(s_axi_araddr) == `LOOP_OFFSET_LOW_IDX)
				s_axi_rdata[7:0] <= r26_reg;
			else if (byte_idx(s_axi_araddr) == `ENVELOPE_ATTENUATION_HIGH_IDX)
				// live attenuation of the selected voice
				s_axi_rdata[7:0] <= {r27_reg[7:2],
					atten_reg[voice_reg[2:0]][9:8]};
			else if (byte_idx(s_axi_araddr) == `ATTENUATION_LOW_IDX)
				s_axi_rdata[7:0] <= atten_reg[voice_reg[2:0]][7:0];
			else if (byte_idx(s_axi_araddr) < `CONVERTER_WORD_HIGH_IDX ||
				byte_idx(s_axi_araddr) > `SYNTH_RANGE_LAST_IDX)
				s_axi_rresp <= `AXI_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	wire [2:0] tv = wr_data[2:0];
	wire [15:0] cur_addr = pos_reg[vidx_reg][27:12];
	wire signed [7:0] s8 = sample_memory_data[7:0];
	wire is_end = sample_memory_data[7:0] == `END_MARKER;
	// attenuated sample of the voice being mixed
	wire signed [15:0] vscaled = scale(samp_reg[vidx_reg], atten_reg[vidx_reg]);

	// output tick and voice scan
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_reg <= 16'h0000;
			env_cnt_reg <= 16'h0000;
			env_step_reg <= 1'b0;
			output_tick <= 1'b0;
			state_reg <= ST_IDLE;
			vidx_reg <= 3'h0;
			acc_reg <= 20'sh00000;
			sample_memory_address <= 16'h0000;
			converter_input_word <= 16'h0000;
			converter_on <= 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				active_reg[i] <= 1'b0;
				atten_reg[i] <= 10'h3FF;
				samp_reg[i] <= 16'sh0000;
				pos_reg[i] <= 28'h0000000;
			end
		end else begin
			converter_on <= conv_ctl_reg[`CONVERTER_ON_BIT];
			output_tick <= 1'b0;
			if (tick_cnt_reg == `TICK_CYCLES - 1) begin
				tick_cnt_reg <= 16'h0000;
				output_tick <= 1'b1;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			end
			case (state_reg)
			ST_IDLE: begin
				if (output_tick) begin
					vidx_reg <= 3'h0;
					acc_reg <= 20'sh00000;
					state_reg <= ST_ADDR;
					if (env_cnt_reg == ENVELOPE_TICKS - 1) begin
						env_cnt_reg <= 16'h0000;
						env_step_reg <= 1'b1;
					end else begin
						env_cnt_reg <= env_cnt_reg + 16'h0001;
						env_step_reg <= 1'b0;
					end
				end
			end
			ST_ADDR: begin
				sample_memory_address <= cur_addr;
				state_reg <= ST_DATA;
			end
			ST_DATA: begin
				if (active_reg[vidx_reg]) begin
					if (is_end) begin
						// keep cycling the loop span
						// carry out of the 10-bit sum is dropped
						pos_reg[vidx_reg] <= {cur_addr[15:10],
							cur_addr[9:0] + loop_reg[vidx_reg], 12'h000};
					end else begin
						samp_reg[vidx_reg] <= wide_reg[vidx_reg] ?
							{sample_memory_data[11:0], 4'h0} : {s8, 8'h00};
						pos_reg[vidx_reg] <= pos_reg[vidx_reg] +
							pitch_inc(mant_reg[vidx_reg], shift_reg[vidx_reg]);
					end
					if (env_step_reg)
						atten_reg[vidx_reg] <= ramp(atten_reg[vidx_reg],
							dir_reg[vidx_reg], span_reg[vidx_reg]);
				end
				state_reg <= ST_MIX;
			end
			ST_MIX: begin
				if (active_reg[vidx_reg])
					acc_reg <= acc_reg + {{4{vscaled[15]}}, vscaled};
				if (vidx_reg == 3'h7) begin
					state_reg <= ST_IDLE;
				end else begin
					vidx_reg <= vidx_reg + 3'h1;
					state_reg <= ST_ADDR;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
			if (!conv_ctl_reg[`OUTPUT_SOURCE_SELECT_BIT])
				converter_input_word <= {conv_hi_reg, conv_lo_reg};
			else if (state_reg == ST_MIX && vidx_reg == 3'h7)
				converter_input_word <= (acc_reg > 20'sh07FFF) ? 16'h7FFF :
					(acc_reg < -20'sh08000) ? 16'h8000 : acc_reg[15:0];
			if (trig) begin
				if (!wr_data[`PITCH_ONLY_UPDATE_BIT])
					atten_reg[tv] <= {r27_reg[1:0], r2a_reg};
				if (!wr_data[`VOLUME_ONLY_UPDATE_BIT] &&
					!wr_data[`PITCH_ONLY_UPDATE_BIT]) begin
					active_reg[tv] <= 1'b1;
					samp_reg[tv] <= 16'sh0000;
					// origin on 32-word boundary
					// start field lands on address bits 15..5
					pos_reg[tv] <= {r23_reg[2:0], r24_reg, 5'b00000, 12'h000};
				end
			end
		end
	end

	// parameter latch on trigger, per update selection
	always @(posedge aclk) begin
		if (trig && !wr_data[`VOLUME_ONLY_UPDATE_BIT]) begin
			mant_reg[tv] <= {r21_reg[3:0], r22_reg};
			shift_reg[tv] <= r21_reg[7:4];
			if (!wr_data[`PITCH_ONLY_UPDATE_BIT]) begin
				origin_reg[tv] <= {r23_reg[3:0], r24_reg};
				wide_reg[tv] <= r25_reg[`SAMPLE_WIDTH_SELECT_BIT];
				loop_reg[tv] <= {r25_reg[1:0], r26_reg};
				dir_reg[tv] <= r27_reg[`RAMP_DIRECTION_BIT];
				span_reg[tv] <= r27_reg[3:2];
			end
		end
	end

endmodule

`default_nettype wire

/* wavetable_voice_engine_asserts.sv */
/*
 * Checker for the wavetable voice engine: bus handshakes, read masks,
 * converter enable after reset and output tick spacing.
 * Assumes byte address = register index * 4 and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wavetable_voice_engine_consts.vh"

module wve_checker #(
	parameter ENVELOPE_TICKS = 2 // output ticks per ramp step
) (
	input wire aclk, // clock
	input wire aresetn, // sync reset, low active
	input wire s_axi_awvalid, // write address valid
	input wire s_axi_awready, // write address ready
	input wire s_axi_wvalid, // write data valid
	input wire s_axi_wready, // write data ready
	input wire [1:0] s_axi_bresp, // write response
	input wire s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [31:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	input wire s_axi_arready, // read address ready
	input wire [31:0] s_axi_rdata, // read data
	input wire [1:0] s_axi_rresp, // read response
	input wire s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire converter_on, // converter enable
	input wire output_tick // output sample pulse
);
	reg [31:0] last_ar;
	reg [12:0] gap;
	reg seen;

	always @(posedge aclk) begin
		if (!aresetn) begin
			gap <= 13'h0000;
			seen <= 1'b0;
		end else begin
			if (s_axi_arvalid && s_axi_arready)
				last_ar <= s_axi_araddr;
			gap <= output_tick ? 13'h0000 : gap + 13'h0001;
			if (output_tick)
				seen <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	property p_write_answer;
		s_wr_taken |=> s_axi_bvalid;
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_unused_zero;
		s_ar_taken ##0 (s_axi_araddr inside {32'hA0, 32'hA4, [32'hAC:32'hBC]})
			|=> s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == `AXI_RESP_OKAY;
	endproperty
	property p_slverr;
		s_ar_taken ##0 (s_axi_araddr < 32'h74 || s_axi_araddr > 32'hBC)
			|=> s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	property p_ctrl_mask;
		s_axi_rvalid && last_ar == 32'h7C |-> s_axi_rdata[31:2] == 30'h0;
	endproperty
	property p_on_reset;
		$rose(aresetn) |-> !converter_on;
	endproperty
	property p_tick_gap;
		output_tick && seen |-> gap == `TICK_CYCLES - 1;
	endproperty

	a_write_answer: assert property (p_write_answer)
		else $error("write response late");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	a_refuse: assert property (p_refuse)
		else $error("write taken during response");
	a_unused_zero: assert property (p_unused_zero)
		else $error("unused address not zero");
	a_slverr: assert property (p_slverr)
		else $error("outside address not refused");
	a_ctrl_mask: assert property (p_ctrl_mask)
		else $error("control spare bits not zero");
	a_on_reset: assert property (p_on_reset)
		else $error("converter on after reset");
	a_tick_gap: assert property (p_tick_gap)
		else $error("output tick spacing wrong");
endmodule

bind wavetable_voice_engine wve_checker #(.ENVELOPE_TICKS(ENVELOPE_TICKS)) chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .converter_on, .output_tick
);
`default_nettype wire

/* wave_rom_model.sv */
/*
 * Wave memory model: answers one clock after the address.
 * Assumes 32-word wave blocks, each ending in the end marker.
 */
`timescale 1ns/1ps
`default_nettype none

module wave_rom_model (
	input wire logic aclk, // clock
	input wire logic [15:0] addr, // sample word address
	output logic [15:0] data // sample word, next cycle
);
	always @(posedge aclk) begin
		if (addr[4:0] == 5'h1F)
			data <= 16'h0080;
		else
			data <= {9'h000, addr[6:0]};
	end
endmodule
`default_nettype wire

/* wavetable_voice_engine_test.sv */
/*
 * Self-checking bench for the wavetable voice engine.
 * Assumes the wave memory model and a bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wavetable_voice_engine_consts.vh"

module wavetable_voice_engine_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, converter_on, output_tick;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] sample_memory_address, sample_memory_data;
	wire [15:0] converter_input_word;
	int bad_count, comparisons, seed, v, i;
	logic [9:0] att [8];
	logic [9:0] st;
	logic [1:0] sp, r;
	logic [31:0] d;
	logic [15:0] w;
	bit up, found;

	wavetable_voice_engine #(.ENVELOPE_TICKS(2)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.sample_memory_address(sample_memory_address),
		.sample_memory_data(sample_memory_data),
		.converter_input_word(converter_input_word),
		.converter_on(converter_on), .output_tick(output_tick)
	);
	wave_rom_model rom (.aclk(aclk), .addr(sample_memory_address),
		.data(sample_memory_data));

	always #5 aclk = ~aclk;

	function automatic logic [9:0] ramp_end(input logic [9:0] a,
		input bit rel, input logic [1:0] s);
		logic [9:0] m;
		m = (s == 2'h0) ? 10'h007 : (s == 2'h1) ? 10'h003 :
			(s == 2'h2) ? 10'h001 : 10'h000;
		return rel ? (a | m) : (a & ~m);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		bit ta, tw, da, dw, tb;
		@(posedge aclk);
		s_axi_awaddr <= {22'h0, idx, 2'b00};
		s_axi_wdata <= {24'h0, val};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			#1;
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
		end while (!(da && dw));
		do begin
			#1 tb = s_axi_bvalid;
			@(posedge aclk);
		end while (!tb);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] q,
		output logic [1:0] rs);
		bit t;
		@(posedge aclk);
		s_axi_araddr <= {22'h0, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		do begin
			#1 t = s_axi_arready;
			@(posedge aclk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			#1 t = s_axi_rvalid;
			@(posedge aclk);
		end while (!t);
		s_axi_rready <= 1'b1;
		#1 q = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask

	task automatic end_of_test;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// about 81000 cycles of tests, so 120000 is a hang
	initial begin
		#1200000;
		bad_count++;
		end_of_test();
	end

	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		seed = $urandom(2929);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1 chk("converter_on", 32'h0, {31'h0, converter_on});
		repeat (4) begin
			w = $urandom;
			wr(8'h1F, 8'hFE);
			wr(8'h1D, w[15:8]);
			wr(8'h1E, w[7:0]);
			repeat (2) @(posedge aclk);
			#1 chk("converter_input_word", {16'h0, w}, {16'h0, converter_input_word});
			chk("converter_on", 32'h1, {31'h0, converter_on});
			rd(8'h1D, d, r);
			chk("converter_word_high", {24'h0, w[15:8]}, d);
		end
		rd(8'h1F, d, r);
		chk("converter_control", 32'h2, d);
		for (i = 8'h28; i <= 8'h2F; i++) begin
			if (i != 8'h2A) begin
				wr(i[7:0], 8'hFF);
				rd(i[7:0], d, r);
				chk("unused", 32'h0, d);
			end
		end
		repeat (3) begin
			rd(8'h30 + 8'($urandom_range(0, 8'hCF)), d, r);
			chk("outside_resp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, r});
		end
		for (v = 0; v < 8; v++) begin
			att[v] = 10'($urandom_range(0, 10'h3FF));
			wr(8'h21, 8'h68);
			wr(8'h22, 8'h00);
			wr(8'h23, 8'h01);
			wr(8'h24, v[7:0]);
			wr(8'h25, 8'h03);
			wr(8'h26, 8'hF0);
			wr(8'h27, {6'h03, att[v][9:8]});
			wr(8'h2A, att[v][7:0]);
			wr(8'h20, v[7:0]);
		end
		for (v = 0; v < 8; v++) begin
			wr(8'h20, 8'hC0 | v[7:0]);
			rd(8'h2A, d, r);
			chk("attenuation_low", {24'h0, att[v][7:0]}, d);
			rd(8'h27, d, r);
			chk("attenuation_high", {30'h0, att[v][9:8]}, {30'h0, d[1:0]});
		end
		wr(8'h2A, 8'h5A);
		wr(8'h20, 8'h43);
		wr(8'h20, 8'hC3);
		rd(8'h2A, d, r);
		chk("pitch_only", {24'h0, att[3][7:0]}, d);
		wr(8'h20, 8'h83);
		rd(8'h2A, d, r);
		chk("volume_only", 32'h5A, d);
		found = 0;
		repeat (8000) begin
			@(posedge aclk);
			if (sample_memory_address[15:5] === 11'h100)
				found = 1;
		end
		chk("wave_origin_fetch", 32'h1, {31'h0, found});
		for (i = 0; i < 6; i++) begin
			up = i < 3;
			sp = 2'(i % 3);
			st = up ? ramp_end(10'h000, 1'b1, sp) - 10'h001 : 10'h009;
			wr(8'h27, {~up, 3'h0, sp, st[9:8]});
			wr(8'h2A, st[7:0]);
			wr(8'h20, 8'h00);
			repeat (3 * `TICK_CYCLES) @(posedge aclk);
			wr(8'h20, 8'hC0);
			rd(8'h2A, d, r);
			chk("ramp_result", {24'h0, ramp_end(st, up, sp)}, d);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
